// File: include/bodec_pkg.sv
// Constants, field layouts and carrier types of the byte-op instruction decoder
package bodec_pkg;

  // Four-bit opcode prefixes
  localparam logic [3:0] OP4_MISC = 4'h0;
  localparam logic [3:0] OP4_LOGIC = 4'h1;
  localparam logic [3:0] OP4_CMP = 4'h6;
  localparam logic [3:0] OP4_BIT_TOGGLE = 4'h7;
  localparam logic [3:0] OP4_BIT_SET = 4'h8;
  localparam logic [3:0] OP4_BIT_CLEAR = 4'h9;
  localparam logic [3:0] OP4_BIT_SKIP_SET = 4'hA;
  localparam logic [3:0] OP4_BIT_SKIP_CLR = 4'hB;
  localparam logic [3:0] OP4_FILE_MOVE = 4'hC;
  localparam logic [3:0] OP4_REL_JUMP = 4'hD;
  localparam logic [3:0] OP4_CONTROL = 4'hE;
  localparam logic [3:0] OP4_SECOND_WORD = 4'hF;

  // Six-bit byte-op codes, word bits 15:10
  localparam logic [5:0] OP6_DEC = 6'h01;
  localparam logic [5:0] OP6_OR = 6'h04;
  localparam logic [5:0] OP6_AND = 6'h05;
  localparam logic [5:0] OP6_XOR = 6'h06;
  localparam logic [5:0] OP6_COMPL = 6'h07;
  localparam logic [5:0] OP6_ADD_W_CARRY = 6'h08;
  localparam logic [5:0] OP6_ADD_W = 6'h09;
  localparam logic [5:0] OP6_INC = 6'h0A;
  localparam logic [5:0] OP6_DEC_SKIP_Z = 6'h0B;
  localparam logic [5:0] OP6_ROT_R_CARRY = 6'h0C;
  localparam logic [5:0] OP6_ROT_L_CARRY = 6'h0D;
  localparam logic [5:0] OP6_NIBBLE_SWAP = 6'h0E;
  localparam logic [5:0] OP6_INC_SKIP_Z = 6'h0F;
  localparam logic [5:0] OP6_ROT_R = 6'h10;
  localparam logic [5:0] OP6_ROT_L = 6'h11;
  localparam logic [5:0] OP6_INC_SKIP_NZ = 6'h12;
  localparam logic [5:0] OP6_DEC_SKIP_NZ = 6'h13;
  localparam logic [5:0] OP6_MOVE_FILE = 6'h14;
  localparam logic [5:0] OP6_SUB_F_W_B = 6'h15;
  localparam logic [5:0] OP6_SUB_W_F_B = 6'h16;
  localparam logic [5:0] OP6_SUB_W_F = 6'h17;

  // Seven-bit codes, word bits 15:9
  localparam logic [6:0] OP7_MULTIPLY = 7'h01;
  localparam logic [6:0] OP7_CMP_LESS = 7'h30;
  localparam logic [6:0] OP7_CMP_EQUAL = 7'h31;
  localparam logic [6:0] OP7_CMP_GREATER = 7'h32;
  localparam logic [6:0] OP7_TEST_ZERO = 7'h33;
  localparam logic [6:0] OP7_STORE_W = 7'h37;
  localparam logic [6:0] OP7_CALL_FIRST = 7'h76;

  // Eight-bit codes, word bits 15:8, and the all-zero 16-bit nop word
  localparam logic [7:0] OP8_JUMP_FIRST = 8'hEF;
  localparam logic [7:0] OP8_LOAD_FIRST = 8'hEE;
  localparam logic [15:0] WORD_NOP = 16'h0000;

  // Status flag positions and update masks
  localparam int FL_C = 0;
  localparam int FL_DC = 1;
  localparam int FL_Z = 2;
  localparam int FL_OV = 3;
  localparam int FL_N = 4;
  localparam logic [4:0] FL_NONE = 5'h00;
  localparam logic [4:0] FL_ALL = 5'h1F;
  localparam logic [4:0] FL_ZN = 5'h14;
  localparam logic [4:0] FL_CZN = 5'h15;

  // Data memory map
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [11:0] PORT_FIRST_ADDR = 12'hF80;
  localparam logic [11:0] PORT_LAST_ADDR = 12'hF84;
  localparam logic [11:0] TIMER_ZERO_ADDR = 12'hFD6;

  typedef enum logic [1:0] {
    ST_FETCH = 2'h0,
    ST_SECOND = 2'h1,
    ST_SQUASH = 2'h3,
    ST_SQUASH2 = 2'h2
  } bodec_state_t;

  typedef enum logic [1:0] {
    PEND_NONE = 2'h0,
    PEND_MOVE = 2'h1,
    PEND_JUMP = 2'h2,
    PEND_CALL = 2'h3
  } bodec_pend_kind_t;

  typedef struct packed {
    bodec_pend_kind_t kind;
    logic fast;
    logic [11:0] field;
  } bodec_pend_t;

  typedef struct packed {
    logic valid;
    logic nop;
    logic [11:0] addr;
    logic [7:0] result;
    logic wr_file;
    logic wr_w;
    logic pin_src;
    logic presc_clear;
    logic [4:0] flags;
    logic [4:0] flag_mask;
    logic skip;
    logic [2:0] bit_sel;
    logic [7:0] literal;
    logic [15:0] product;
    logic move;
    logic [11:0] move_src;
    logic jump;
    logic rel;
    logic call;
    logic fast;
    logic [10:0] offset;
    logic [19:0] target;
  } bodec_exec_t;

endpackage

// File: verilog/bodec_decoder.sv
// Byte-op instruction decoder and byte-op execute control
`timescale 1ns/1ps

module bodec_decoder
  import bodec_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Program memory word
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  // Core state and operands for the current word
  input wire logic [7:0] working_register,
  input wire logic [3:0] bank_select_register,
  input wire logic [4:0] status_in,
  input wire logic [7:0] file_latch_data,
  input wire logic [7:0] pin_data,
  // Decoded execution control
  output bodec_exec_t exec_q
);

  bodec_state_t st_q;
  bodec_state_t st_d;
  bodec_pend_t pend_q;
  bodec_pend_t pend_d;
  bodec_exec_t exec_d;

  logic take_fetch;
  logic [5:0] op6;
  logic [6:0] op7;
  logic [11:0] eff_addr;
  logic is_port;
  logic [7:0] opnd;
  logic [7:0] bit_mask;
  logic two_word_first;

  logic [7:0] add_a;
  logic [7:0] add_b;
  logic add_cin;
  logic [8:0] add_sum;
  logic [4:0] add_low;
  logic add_ov;

  logic [7:0] res;
  logic carry_v;
  logic [2:0] cond_flag;
  logic cond_taken;

  assign take_fetch = instr_valid && (st_q == ST_FETCH);
  assign op6 = instr_word[15:10];
  assign op7 = instr_word[15:9];

  // Effective data address from the a bit and the low-byte file field
  always_comb begin
    if (instr_word[8]) begin
      eff_addr = {bank_select_register, instr_word[7:0]};
    end else if (instr_word[7:0] >= ACCESS_SPLIT) begin
      eff_addr = {ACCESS_HI_BANK, instr_word[7:0]};
    end else begin
      eff_addr = {ACCESS_LO_BANK, instr_word[7:0]};
    end
  end

  // Ports read back their pin levels, not the output latch
  assign is_port = (eff_addr >= PORT_FIRST_ADDR) && (eff_addr <= PORT_LAST_ADDR);
  assign opnd = is_port ? pin_data : file_latch_data;
  assign bit_mask = 8'h01 << instr_word[11:9];

  assign two_word_first = (instr_word[15:12] == OP4_FILE_MOVE) || (instr_word[15:8] == OP8_JUMP_FIRST)
    || (instr_word[15:8] == OP8_LOAD_FIRST) || (op7 == OP7_CALL_FIRST);

  // Shared adder operands
  always_comb begin
    add_a = opnd;
    add_b = working_register;
    add_cin = 1'b0;
    case (op6)
      OP6_ADD_W_CARRY: begin
        add_cin = status_in[FL_C];
      end
      OP6_INC, OP6_INC_SKIP_Z, OP6_INC_SKIP_NZ: begin
        add_b = 8'h00;
        add_cin = 1'b1;
      end
      OP6_DEC, OP6_DEC_SKIP_Z, OP6_DEC_SKIP_NZ: begin
        add_b = 8'hFF;
      end
      OP6_SUB_W_F: begin
        add_b = ~working_register;
        add_cin = 1'b1;
      end
      OP6_SUB_W_F_B: begin
        add_b = ~working_register;
        add_cin = status_in[FL_C];
      end
      OP6_SUB_F_W_B: begin
        add_a = working_register;
        add_b = ~opnd;
        add_cin = status_in[FL_C];
      end
      default: begin
        add_cin = 1'b0;
      end
    endcase
  end

  // Carry out means no borrow when subtracting, for both nibble and byte
  assign add_sum = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_cin};
  assign add_low = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
  assign add_ov = (add_a[7] == add_b[7]) && (add_sum[7] != add_a[7]);

  // Conditional branch flag select: Z, C, OV, N; low bit inverts
  always_comb begin
    case (instr_word[10:9])
      2'h0: cond_flag = 3'(FL_Z);
      2'h1: cond_flag = 3'(FL_C);
      2'h2: cond_flag = 3'(FL_OV);
      default: cond_flag = 3'(FL_N);
    endcase
  end
  assign cond_taken = status_in[cond_flag] ^ instr_word[8];

  // Decode of the current word
  always_comb begin
    exec_d = '0;
    st_d = st_q;
    pend_d = pend_q;
    res = 8'h00;
    carry_v = add_sum[8];
    exec_d.valid = instr_valid;
    if (instr_valid) begin
      case (st_q)
        ST_SECOND: begin
          st_d = ST_FETCH;
          pend_d.kind = PEND_NONE;
          exec_d.nop = (pend_q.kind == PEND_NONE);
          exec_d.move = (pend_q.kind == PEND_MOVE);
          exec_d.move_src = pend_q.field;
          exec_d.addr = instr_word[11:0];
          exec_d.jump = (pend_q.kind == PEND_JUMP) || (pend_q.kind == PEND_CALL);
          exec_d.call = (pend_q.kind == PEND_CALL);
          exec_d.fast = pend_q.fast;
          exec_d.target = {instr_word[11:0], pend_q.field[7:0]};
        end
        ST_SQUASH: begin
          exec_d.nop = 1'b1;
          st_d = two_word_first ? ST_SQUASH2 : ST_FETCH;
        end
        ST_SQUASH2: begin
          exec_d.nop = 1'b1;
          st_d = ST_FETCH;
        end
        default: begin
          exec_d.addr = eff_addr;
          exec_d.literal = instr_word[7:0];
          exec_d.bit_sel = instr_word[11:9];
          exec_d.flag_mask = FL_NONE;
          case (instr_word[15:12])
            OP4_MISC, OP4_LOGIC, 4'h2, 4'h3, 4'h4, 4'h5: begin
              exec_d.nop = (instr_word == WORD_NOP);
              if (op7 == OP7_MULTIPLY) begin
                exec_d.product = {8'h00, working_register} * {8'h00, opnd};
              end else if (op6 == OP6_DEC || instr_word[15:12] != OP4_MISC) begin
                exec_d.wr_w = ~instr_word[9];
                exec_d.wr_file = instr_word[9];
                exec_d.pin_src = is_port;
                res = add_sum[7:0];
                case (op6)
                  OP6_DEC, OP6_ADD_W, OP6_INC, OP6_ADD_W_CARRY,
                  OP6_SUB_W_F, OP6_SUB_W_F_B, OP6_SUB_F_W_B: begin
                    exec_d.flag_mask = FL_ALL;
                  end
                  OP6_OR: begin
                    res = opnd | working_register;
                    exec_d.flag_mask = FL_ZN;
                  end
                  OP6_AND: begin
                    res = opnd & working_register;
                    exec_d.flag_mask = FL_ZN;
                  end
                  OP6_XOR: begin
                    res = opnd ^ working_register;
                    exec_d.flag_mask = FL_ZN;
                  end
                  OP6_COMPL: begin
                    res = ~opnd;
                    exec_d.flag_mask = FL_ZN;
                  end
                  OP6_ROT_R_CARRY: begin
                    res = {status_in[FL_C], opnd[7:1]};
                    carry_v = opnd[0];
                    exec_d.flag_mask = FL_CZN;
                  end
                  OP6_ROT_L_CARRY: begin
                    res = {opnd[6:0], status_in[FL_C]};
                    carry_v = opnd[7];
                    exec_d.flag_mask = FL_CZN;
                  end
                  OP6_ROT_R: begin
                    res = {opnd[0], opnd[7:1]};
                    exec_d.flag_mask = FL_ZN;
                  end
                  OP6_ROT_L: begin
                    res = {opnd[6:0], opnd[7]};
                    exec_d.flag_mask = FL_ZN;
                  end
                  OP6_NIBBLE_SWAP: begin
                    res = {opnd[3:0], opnd[7:4]};
                  end
                  OP6_MOVE_FILE: begin
                    res = opnd;
                    exec_d.flag_mask = FL_ZN;
                  end
                  OP6_DEC_SKIP_Z, OP6_INC_SKIP_Z: begin
                    exec_d.skip = (add_sum[7:0] == 8'h00);
                  end
                  OP6_DEC_SKIP_NZ, OP6_INC_SKIP_NZ: begin
                    exec_d.skip = (add_sum[7:0] != 8'h00);
                  end
                  default: begin
                    exec_d.wr_w = 1'b0;
                    exec_d.wr_file = 1'b0;
                  end
                endcase
              end
            end
            OP4_CMP: begin
              case (op7)
                OP7_CMP_LESS: exec_d.skip = (opnd < working_register);
                OP7_CMP_EQUAL: exec_d.skip = (opnd == working_register);
                OP7_CMP_GREATER: exec_d.skip = (opnd > working_register);
                OP7_TEST_ZERO: exec_d.skip = (opnd == 8'h00);
                OP7_STORE_W: begin
                  res = working_register;
                  exec_d.wr_file = 1'b1;
                end
                default: exec_d.skip = 1'b0;
              endcase
            end
            OP4_BIT_TOGGLE, OP4_BIT_SET, OP4_BIT_CLEAR: begin
              exec_d.wr_file = 1'b1;
              exec_d.pin_src = is_port;
              if (instr_word[15:12] == OP4_BIT_TOGGLE) begin
                res = opnd ^ bit_mask;
              end else if (instr_word[15:12] == OP4_BIT_SET) begin
                res = opnd | bit_mask;
              end else begin
                res = opnd & ~bit_mask;
              end
            end
            OP4_BIT_SKIP_SET: exec_d.skip = |(opnd & bit_mask);
            OP4_BIT_SKIP_CLR: exec_d.skip = ~|(opnd & bit_mask);
            OP4_FILE_MOVE: begin
              pend_d = '{kind: PEND_MOVE, fast: 1'b0, field: instr_word[11:0]};
              st_d = ST_SECOND;
            end
            OP4_REL_JUMP: begin
              exec_d.jump = 1'b1;
              exec_d.rel = 1'b1;
              exec_d.call = instr_word[11];
              exec_d.offset = instr_word[10:0];
            end
            OP4_CONTROL: begin
              if (instr_word[15:8] == OP8_JUMP_FIRST) begin
                pend_d = '{kind: PEND_JUMP, fast: 1'b0, field: instr_word[11:0]};
                st_d = ST_SECOND;
              end else if (op7 == OP7_CALL_FIRST) begin
                pend_d = '{kind: PEND_CALL, fast: instr_word[8], field: instr_word[11:0]};
                st_d = ST_SECOND;
              end else if (instr_word[15:8] == OP8_LOAD_FIRST) begin
                pend_d = '{kind: PEND_NONE, fast: 1'b0, field: instr_word[11:0]};
                st_d = ST_SECOND;
              end else if (!instr_word[11]) begin
                exec_d.jump = cond_taken;
                exec_d.rel = cond_taken;
                exec_d.offset = {{3{instr_word[7]}}, instr_word[7:0]};
              end
            end
            default: begin
              exec_d.nop = 1'b1;
            end
          endcase
          exec_d.result = res;
          exec_d.flags = {res[7], add_ov, res == 8'h00, add_low[4], carry_v};
          exec_d.presc_clear = exec_d.wr_file && (eff_addr == TIMER_ZERO_ADDR);
          if (exec_d.skip || exec_d.rel) begin
            st_d = ST_SQUASH;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= ST_FETCH;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      exec_q <= '0;
    end else begin
      exec_q <= exec_d;
    end
  end

  a_dest_logic_flags: assert property (
    @(posedge clk) disable iff (srst)
    take_fetch && instr_word[15:12] == OP4_LOGIC |=>
      exec_q.wr_w == !$past(instr_word[9]) && exec_q.wr_file == $past(instr_word[9]) && exec_q.flag_mask == FL_ZN)
    else $error("logic op destination or flags wrong");

  a_bank_select: assert property (
    @(posedge clk) disable iff (srst)
    take_fetch && instr_word[15:12] == OP4_LOGIC && instr_word[8] |=>
      exec_q.addr == {$past(bank_select_register), $past(instr_word[7:0])})
    else $error("banked address wrong");

  a_access_low: assert property (
    @(posedge clk) disable iff (srst)
    take_fetch && instr_word[15:12] == OP4_LOGIC && !instr_word[8] && !instr_word[7] |=>
      exec_q.addr[11:8] == ACCESS_LO_BANK)
    else $error("access bank address wrong");

  a_sub_no_borrow: assert property (
    @(posedge clk) disable iff (srst)
    take_fetch && op6 == OP6_SUB_W_F |=>
      exec_q.flags[FL_C] == ($past(opnd) >= $past(working_register)) && exec_q.flag_mask == FL_ALL)
    else $error("subtract carry wrong");

  a_skip_no_flags: assert property (
    @(posedge clk) disable iff (srst)
    take_fetch && (op6 == OP6_DEC_SKIP_Z || op6 == OP6_INC_SKIP_NZ || instr_word[15:12] == OP4_CMP) |=>
      exec_q.flag_mask == FL_NONE)
    else $error("skip op altered flags");

  a_mul_no_flags: assert property (
    @(posedge clk) disable iff (srst)
    take_fetch && op7 == OP7_MULTIPLY |=>
      exec_q.flag_mask == FL_NONE && exec_q.product == {8'h00, $past(working_register)} * {8'h00, $past(opnd)})
    else $error("multiply result or flags wrong");

  a_flush_after_jump: assert property (
    @(posedge clk) disable iff (srst)
    exec_q.valid && (exec_q.rel || exec_q.skip) && instr_valid |=> exec_q.nop)
    else $error("word after jump or skip not flushed");

  a_stray_second_nop: assert property (
    @(posedge clk) disable iff (srst)
    take_fetch && instr_word[15:12] == OP4_SECOND_WORD |=> exec_q.nop && !exec_q.wr_file && !exec_q.jump)
    else $error("stray second word not a nop");

  a_jump_target: assert property (
    @(posedge clk) disable iff (srst)
    take_fetch && instr_word[15:8] == OP8_JUMP_FIRST ##1 instr_valid |=>
      exec_q.jump && exec_q.target == {$past(instr_word[11:0]), $past(instr_word[7:0], 2)})
    else $error("absolute target wrong");

  a_timer_presc: assert property (
    @(posedge clk) disable iff (srst)
    take_fetch && op6 == OP6_INC && instr_word[9] && eff_addr == TIMER_ZERO_ADDR |=> exec_q.presc_clear)
    else $error("prescaler clear missing");

endmodule

// File: dv/bodec_mem_model.sv
// Data memory and port pin model facing the decoder
`timescale 1ns/1ps
module bodec_mem_model
  import bodec_pkg::*;
(
  // Effective address of the word
  input wire logic [11:0] addr,
  // Operand data
  output logic [7:0] file_latch_data,
  output logic [7:0] pin_data
);
  logic [7:0] mem [0:4095];
  logic [7:0] pins [0:4095];
  logic port;
  assign port = (addr >= PORT_FIRST_ADDR) && (addr <= PORT_LAST_ADDR);
  assign file_latch_data = mem[addr];
  // Off-port pins never echo the latch
  assign pin_data = port ? pins[addr] : ~mem[addr];
  task automatic poke(input logic [11:0] a, input logic [7:0] d, input logic [7:0] p);
    mem[a] = d;
    pins[a] = p;
  endtask
endmodule

// File: dv/tb_top.sv
// Self-checking bench of the byte-op decoder
`timescale 1ns/1ps
module tb_top
  import bodec_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0] working_register = 8'h00;
  logic [3:0] bank_select_register = 4'h0;
  logic [4:0] status_in = 5'h00;
  logic [11:0] addr = 12'h000;
  logic [7:0] file_latch_data;
  logic [7:0] pin_data;
  bodec_exec_t exec_q;
  int n_errors = 0;
  int checks = 0;

  always #2.5 clk = ~clk;

  bodec_decoder bodec_decoder_inst (
    .clk(clk),
    .srst(srst),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .working_register(working_register),
    .bank_select_register(bank_select_register),
    .status_in(status_in),
    .file_latch_data(file_latch_data),
    .pin_data(pin_data),
    .exec_q(exec_q)
  );

  bodec_mem_model bodec_mem_model_inst (
    .addr(addr),
    .file_latch_data(file_latch_data),
    .pin_data(pin_data)
  );

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [11:0] eff(input logic [15:0] wd);
    if (wd[8]) begin
      return {bank_select_register, wd[7:0]};
    end
    return {(wd[7:0] < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK, wd[7:0]};
  endfunction

  function automatic logic [15:0] bop(input logic [5:0] op, input logic d, input logic a, input logic [7:0] f);
    return {op, d, a, f};
  endfunction

  // Word taken at the next edge, result looked at 1 ns after that same edge
  task automatic send(input logic [15:0] wd);
    instr_word = wd;
    instr_valid = 1'b1;
    addr = eff(wd);
    @(posedge clk);
    #1;
  endtask

  task automatic idle();
    instr_valid = 1'b0;
    @(posedge clk);
    #1;
    chk("valid", 20'h0_0000, exec_q.valid);
  endtask

  task automatic op_case(input logic [15:0] wd, input logic [7:0] f, input logic [7:0] w, input logic c,
                         input logic [7:0] res, input logic [4:0] fl, input logic [4:0] mk);
    working_register = w;
    status_in = {4'h0, c};
    bodec_mem_model_inst.poke(eff(wd), f, ~f);
    send(wd);
    chk("result", res, exec_q.result);
    chk("flags", fl, exec_q.flags & mk);
    chk("mask", mk, exec_q.flag_mask);
  endtask

  task automatic s_arith();
    bank_select_register = 4'h2;
    op_case(bop(OP6_ADD_W_CARRY, 1, 1, 8'h10), 8'h01, 8'h7F, 1, 8'h81, 5'h1A, FL_ALL);
    chk("addr", 12'h210, exec_q.addr);
    chk("wr_file", 1, exec_q.wr_file);
    chk("wr_w", 0, exec_q.wr_w);
    op_case(bop(OP6_ADD_W_CARRY, 0, 0, 8'h90), 8'h01, 8'h7F, 0, 8'h80, 5'h1A, FL_ALL);
    chk("addr", 12'hF90, exec_q.addr);
    chk("wr_w", 1, exec_q.wr_w);
    op_case(bop(OP6_SUB_W_F, 0, 0, 8'h20), 8'h05, 8'h06, 1, 8'hFF, 5'h10, FL_ALL);
    chk("addr", 12'h020, exec_q.addr);
    op_case(bop(OP6_SUB_F_W_B, 0, 0, 8'h20), 8'h01, 8'h10, 1, 8'h0F, 5'h01, FL_ALL);
    op_case(bop(OP6_SUB_W_F_B, 0, 0, 8'h20), 8'h03, 8'h03, 1, 8'h00, 5'h07, FL_ALL);
    op_case(bop(OP6_SUB_W_F_B, 0, 0, 8'h20), 8'h03, 8'h02, 0, 8'h00, 5'h07, FL_ALL);
  endtask

  task automatic s_logic_rot();
    op_case(bop(OP6_OR, 0, 0, 8'h20), 8'h3C, 8'hF0, 1, 8'hFC, 5'h10, FL_ZN);
    op_case(bop(OP6_AND, 0, 1, 8'h20), 8'h3C, 8'hF0, 1, 8'h30, 5'h00, FL_ZN);
    chk("addr", 12'h220, exec_q.addr);
    op_case(bop(OP6_XOR, 0, 0, 8'h20), 8'h3C, 8'hF0, 1, 8'hCC, 5'h10, FL_ZN);
    op_case(bop(OP6_XOR, 0, 0, 8'h20), 8'h3C, 8'h3C, 1, 8'h00, 5'h04, FL_ZN);
    op_case(bop(OP6_COMPL, 0, 0, 8'h20), 8'h3C, 8'hF0, 1, 8'hC3, 5'h10, FL_ZN);
    op_case(bop(OP6_ROT_L_CARRY, 0, 0, 8'h20), 8'h81, 8'h00, 0, 8'h02, 5'h01, FL_CZN);
    op_case(bop(OP6_ROT_R_CARRY, 0, 0, 8'h20), 8'h81, 8'h00, 0, 8'h40, 5'h01, FL_CZN);
    op_case(bop(OP6_ROT_L, 0, 0, 8'h20), 8'h81, 8'h00, 0, 8'h03, 5'h00, FL_ZN);
    op_case(bop(OP6_ROT_R, 0, 0, 8'h20), 8'h81, 8'h00, 0, 8'hC0, 5'h10, FL_ZN);
    op_case(bop(OP6_NIBBLE_SWAP, 0, 0, 8'h20), 8'h3C, 8'h00, 0, 8'hC3, 5'h00, FL_NONE);
    chk("wr_w", 1, exec_q.wr_w);
    op_case(bop(OP6_MOVE_FILE, 1, 0, 8'h20), 8'h00, 8'h55, 0, 8'h00, 5'h04, FL_ZN);
    chk("wr_file", 1, exec_q.wr_file);
    op_case({OP4_BIT_TOGGLE, 3'h2, 1'b0, 8'h20}, 8'h3C, 8'h00, 0, 8'h38, 5'h00, FL_NONE);
    op_case({OP4_BIT_CLEAR, 3'h3, 1'b0, 8'h20}, 8'h3C, 8'h00, 0, 8'h34, 5'h00, FL_NONE);
    op_case({OP4_BIT_SET, 3'h0, 1'b0, 8'h20}, 8'h3C, 8'h00, 0, 8'h3D, 5'h00, FL_NONE);
  endtask

  task automatic skip_case(input logic [15:0] wd, input logic [7:0] f, input logic [7:0] w, input logic sk);
    working_register = w;
    bodec_mem_model_inst.poke(eff(wd), f, ~f);
    send(wd);
    chk("skip", sk, exec_q.skip);
    chk("mask", FL_NONE, exec_q.flag_mask);
    send(bop(OP6_OR, 0, 0, 8'h20));
    chk("nop", sk, exec_q.nop);
  endtask

  task automatic s_skip();
    skip_case({OP7_CMP_EQUAL, 1'b0, 8'h20}, 8'h05, 8'h05, 1);
    skip_case({OP7_CMP_GREATER, 1'b0, 8'h20}, 8'h06, 8'h05, 1);
    skip_case({OP7_CMP_LESS, 1'b0, 8'h20}, 8'h06, 8'h05, 0);
    skip_case({OP7_CMP_LESS, 1'b0, 8'h20}, 8'h04, 8'h05, 1);
    skip_case(bop(OP6_DEC_SKIP_Z, 0, 0, 8'h20), 8'h01, 8'h00, 1);
    skip_case(bop(OP6_DEC_SKIP_NZ, 0, 0, 8'h20), 8'h01, 8'h00, 0);
    skip_case(bop(OP6_INC_SKIP_Z, 0, 0, 8'h20), 8'hFF, 8'h00, 1);
    skip_case(bop(OP6_INC_SKIP_NZ, 0, 0, 8'h20), 8'hFF, 8'h00, 0);
    skip_case({OP7_TEST_ZERO, 1'b0, 8'h20}, 8'h00, 8'h00, 1);
    skip_case({OP7_TEST_ZERO, 1'b0, 8'h20}, 8'h01, 8'h00, 0);
    skip_case({OP4_BIT_SKIP_SET, 3'h5, 1'b0, 8'h20}, 8'h3C, 8'h00, 1);
    skip_case({OP4_BIT_SKIP_CLR, 3'h0, 1'b0, 8'h20}, 8'h3C, 8'h00, 1);
    skip_case({OP4_BIT_SKIP_CLR, 3'h2, 1'b0, 8'h20}, 8'h3C, 8'h00, 0);
  endtask

  task automatic s_mul_side();
    working_register = 8'h10;
    bodec_mem_model_inst.poke(12'h020, 8'h12, 8'h00);
    send({OP7_MULTIPLY, 1'b0, 8'h20});
    chk("product", 16'h0120, exec_q.product);
    chk("mask", FL_NONE, exec_q.flag_mask);
    working_register = 8'h00;
    bodec_mem_model_inst.poke(12'hF81, 8'hFF, 8'h0F);
    send(bop(OP6_OR, 1, 0, 8'h81));
    chk("nop", 0, exec_q.nop);
    chk("result", 8'h0F, exec_q.result);
    chk("pin_src", 1, exec_q.pin_src);
    bodec_mem_model_inst.poke(TIMER_ZERO_ADDR, 8'h10, 8'h00);
    send(bop(OP6_INC, 1, 0, 8'hD6));
    chk("presc_clear", 1, exec_q.presc_clear);
    send(bop(OP6_INC, 0, 0, 8'hD6));
    chk("presc_clear", 0, exec_q.presc_clear);
  endtask

  task automatic s_formats();
    send(16'hC123);
    chk("move", 0, exec_q.move);
    chk("valid", 1, exec_q.valid);
    chk("nop", 0, exec_q.nop);
    send(16'hF456);
    chk("move", 1, exec_q.move);
    chk("move_src", 12'h123, exec_q.move_src);
    chk("addr", 12'h456, exec_q.addr);
    send(16'hEF12);
    send(16'hF345);
    chk("jump", 1, exec_q.jump);
    chk("target", 20'h3_4512, exec_q.target);
    send(16'hED34);
    send(16'hFABC);
    chk("call", 1, exec_q.call);
    chk("fast", 1, exec_q.fast);
    chk("target", 20'hA_BC34, exec_q.target);
    send(16'hF000);
    chk("nop", 1, exec_q.nop);
    send(16'hD123);
    chk("offset", 11'h123, exec_q.offset);
    chk("rel", 1, exec_q.rel);
    chk("call", 0, exec_q.call);
    send(bop(OP6_OR, 0, 0, 8'h20));
    chk("nop", 1, exec_q.nop);
    send(16'hD805);
    chk("call", 1, exec_q.call);
    chk("offset", 11'h005, exec_q.offset);
    status_in = 5'h04;
    send(16'hE0F0);
    chk("nop", 1, exec_q.nop);
    send(16'hE0F0);
    chk("jump", 1, exec_q.jump);
    chk("offset", 11'h7F0, exec_q.offset);
    send(16'hE1F0);
    chk("nop", 1, exec_q.nop);
    send(16'hE1F0);
    chk("jump", 0, exec_q.jump);
    chk("nop", 0, exec_q.nop);
    send({OP4_BIT_SET, 3'h5, 1'b0, 8'h20});
    chk("bit_sel", 3'h5, exec_q.bit_sel);
    send(16'h0F7E);
    chk("literal", 8'h7E, exec_q.literal);
  endtask

  // Reset in the middle of a two-word pair drops the pending first word
  task automatic s_reset();
    send(16'hEF12);
    srst = 1'b1;
    @(posedge clk);
    #1;
    srst = 1'b0;
    chk("exec_zero", 20'h0_0000, {19'h0, exec_q != '0});
    send(16'hF345);
    chk("nop", 1, exec_q.nop);
    chk("jump", 0, exec_q.jump);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    #1;
    srst = 1'b0;
    chk("exec_zero", 20'h0_0000, {19'h0, exec_q != '0});
    s_arith();
    s_logic_rot();
    s_skip();
    s_mul_side();
    s_formats();
    s_reset();
    idle();
    print_verdict();
  end
endmodule
